// ===== design/ads_aperture_sync.sv
// Purpose: Aperture delay and reference clock sync configuration, with its
//          serial configuration slave.
// Assumes: Serial pins are synchronous to core_clk; SCLK is well below it.
// Notes:   Frame is 8 header bits (R/W first, address last) and 16 data
//          bits, MSB first; read data leaves on falling serial clock edges.
//
// Overview of operation
// R1 - Coarse code sets sampling clock delay
// R2 - Coarse codes at saturation hold maximum delay
// R3 - Enable bit gates coarse and fine delay
// R4 - Duty stabiliser on; zero in bit 2 disables
// R5 - Software writes zero to coarse bits 1:0
// R6 - Fine six-bit code adds extra delay
// R7 - No adjust in interleaved mode above 1600 MHz
// R8 - Avoid maximum delay at top clock rate
// R9 - Nine-bit reference delay, saturating at top
// R10 - Phase field picks reference latch phase
// R11 - Bit 2 selects slave alignment to reference
// R12 - Bit 1 zero drives quarter-rate reference outputs
// R13 - Bit 0 one disables output clock reset
// R14 - Software keeps sync bits 6:5 at defaults
// R15 - Total delay is coarse plus fine
`include "ads_regs.svh"

module ads_aperture_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Serial configuration pins
    input wire logic scs_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // Aperture delay control to the analog delay line
    output logic [19:0] aperture_delay_fs,
    output logic delay_adjust_active,
    output logic duty_stabiliser_enable,
    // Reference clock sync
    input wire logic refclk_in,
    input wire logic output_clock_reset_in,
    output logic [8:0] refclk_delay,
    output logic refclk_latched,
    output logic sync_slave_mode,
    output logic refclk_out_a,
    output logic refclk_out_b,
    output logic refclk_out_oe,
    output logic outclk
);

    ////////////////////////////////////////////////////////////////////////
    // Serial configuration slave

    ads_pkg::ads_ser_state_t ser_state;
    ads_pkg::ads_ser_state_t next_ser_state;
    logic sclk_prev;
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic [23:0] shift_in;
    logic [23:0] next_shift_in;
    logic [15:0] shift_out;
    logic [15:0] next_shift_out;
    logic is_read;
    logic next_is_read;
    logic [3:0] addr;
    logic [3:0] next_addr;
    logic next_sdo;
    logic wr_en;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    logic sclk_rise;
    logic sclk_fall;
    logic [3:0] hdr_addr;

    // Registers
    logic [15:0] coarse_reg;
    logic [15:0] fine_reg;
    logic [15:0] sync_reg;

    // Edges of the sampled serial clock, and the address as it completes
    assign sclk_rise = sclk && !sclk_prev;
    assign sclk_fall = !sclk && sclk_prev;
    assign hdr_addr = {shift_in[`ADS_HDR_ADDR_MSB:0], sdi};

    // Read mux fed straight from the shifter, so no loop through sequencing
    always_comb begin
        if (hdr_addr == `ADS_ADDR_COARSE) begin
            rd_data = coarse_reg & `ADS_COARSE_RSVD_MASK;
        end else if (hdr_addr == `ADS_ADDR_FINE) begin
            rd_data = fine_reg & `ADS_FINE_RSVD_MASK;
        end else if (hdr_addr == `ADS_ADDR_SYNC) begin
            rd_data = sync_reg;
        end else begin
            rd_data = 16'h0000;
        end
    end

    // Frame sequencing; raising the select aborts any frame at once
    always_comb begin
        next_ser_state = ser_state;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_shift_out = shift_out;
        next_is_read = is_read;
        next_addr = addr;
        next_sdo = sdo;
        wr_en = 1'b0;
        wr_data = {shift_in[14:0], sdi};
        if (scs_n) begin
            next_ser_state = ads_pkg::ADS_SER_IDLE;
            next_bit_cnt = 5'h00;
            next_sdo = 1'b0;
        end else begin
            case (ser_state)
                ads_pkg::ADS_SER_IDLE: begin
                    next_ser_state = ads_pkg::ADS_SER_HDR;
                    next_bit_cnt = 5'h00;
                    next_is_read = 1'b0;
                    if (sclk_rise) begin
                        next_shift_in = {shift_in[22:0], sdi};
                        next_bit_cnt = 5'h01;
                    end
                end
                ads_pkg::ADS_SER_HDR: begin
                    if (sclk_rise) begin
                        next_shift_in = {shift_in[22:0], sdi};
                        next_bit_cnt = bit_cnt + 5'h01;
                        if (bit_cnt == `ADS_HDR_LAST) begin
                            next_is_read = shift_in[`ADS_HDR_RW_BIT];
                            next_addr = hdr_addr;
                            next_shift_out = rd_data;
                            next_ser_state = ads_pkg::ADS_SER_DATA;
                        end
                    end
                end
                ads_pkg::ADS_SER_DATA: begin
                    // Read data shifts out on falling edges, MSB first
                    if (sclk_fall && is_read) begin
                        next_sdo = shift_out[15];
                        next_shift_out = {shift_out[14:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        next_shift_in = {shift_in[22:0], sdi};
                        next_bit_cnt = bit_cnt + 5'h01;
                        if (bit_cnt == `ADS_FRAME_LAST) begin
                            wr_en = !is_read;
                            next_ser_state = ads_pkg::ADS_SER_DONE;
                        end
                    end
                end
                ads_pkg::ADS_SER_DONE: begin
                    // Extra clocks are ignored until the select rises
                    next_ser_state = ads_pkg::ADS_SER_DONE;
                end
                default: begin
                    next_ser_state = ads_pkg::ADS_SER_IDLE;
                end
            endcase
        end
    end

    // Serial state registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ser_state <= ads_pkg::ADS_SER_IDLE;
            sclk_prev <= 1'b0;
            bit_cnt <= 5'h00;
            shift_in <= 24'h000000;
            shift_out <= 16'h0000;
            is_read <= 1'b0;
            addr <= 4'h0;
            sdo <= 1'b0;
        end else begin
            ser_state <= next_ser_state;
            sclk_prev <= sclk;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            shift_out <= next_shift_out;
            is_read <= next_is_read;
            addr <= next_addr;
            sdo <= next_sdo;
        end
    end

    // Drive the data pin only through the data phase of a read
    assign sdo_oe = !scs_n && is_read && (ser_state == ads_pkg::ADS_SER_DATA);

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic [15:0] next_coarse_reg;
    logic [15:0] next_fine_reg;
    logic [15:0] next_sync_reg;

    // Write decode; other addresses are ignored
    always_comb begin
        next_coarse_reg = coarse_reg;
        next_fine_reg = fine_reg;
        next_sync_reg = sync_reg;
        if (wr_en && (addr == `ADS_ADDR_COARSE)) begin
            // Low bits are kept at zero whatever software sends [R5]
            next_coarse_reg = wr_data & `ADS_COARSE_RSVD_MASK;
        end else if (wr_en && (addr == `ADS_ADDR_FINE)) begin
            next_fine_reg = wr_data & `ADS_FINE_RSVD_MASK;
        end else if (wr_en && (addr == `ADS_ADDR_SYNC)) begin
            // Bits 6:5 stored as written; software keeps defaults [R14]
            next_sync_reg = wr_data;
        end
    end

    // Register storage, at power-on values after reset
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            coarse_reg <= `ADS_RST_COARSE;
            fine_reg <= `ADS_RST_FINE;
            sync_reg <= `ADS_RST_SYNC;
        end else begin
            coarse_reg <= next_coarse_reg;
            fine_reg <= next_fine_reg;
            sync_reg <= next_sync_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Aperture delay

    logic [11:0] cam_clamped;
    logic [8:0] drc_clamped;
    logic [19:0] next_aperture_delay_fs;
    logic sta_on;

    assign sta_on = coarse_reg[`ADS_STA_BIT];

    // Coarse code held at its maximum from the saturation code up [R2]
    ads_sat_clamp #(
        .WIDTH(12)
    ) u_cam_clamp (
        .code_in(coarse_reg[`ADS_CAM_MSB:`ADS_CAM_LSB]),
        .code_max(`ADS_CAM_MAX),
        .code_out(cam_clamped)
    );

    // Reference delay held at maximum for the top code range [R9]
    ads_sat_clamp #(
        .WIDTH(9)
    ) u_drc_clamp (
        .code_in(sync_reg[`ADS_DRC_MSB:`ADS_DRC_LSB]),
        .code_max(`ADS_DRC_MAX),
        .code_out(drc_clamped)
    );

    // Sum of coarse and fine steps; zero while adjust is off
    // Step sizes are nominal; process spread is left to the analog side
    always_comb begin
        if (sta_on) begin // [R3]
            next_aperture_delay_fs =
                ({8'h00, cam_clamped} * `ADS_COARSE_STEP_FS) + // [R1]
                ({14'h0000, fine_reg[`ADS_FAM_MSB:`ADS_FAM_LSB]} *
                 `ADS_FINE_STEP_FS); // [R6] [R15]
        end else begin
            next_aperture_delay_fs = 20'h00000;
        end
    end

    // Delay outputs come from flops so the analog line sees clean codes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            aperture_delay_fs <= 20'h00000;
            delay_adjust_active <= 1'b0;
            duty_stabiliser_enable <= 1'b1;
            refclk_delay <= 9'h000;
        end else begin
            aperture_delay_fs <= next_aperture_delay_fs;
            delay_adjust_active <= sta_on; // [R3]
            duty_stabiliser_enable <= coarse_reg[`ADS_DCC_BIT]; // [R4]
            refclk_delay <= drc_clamped; // [R9]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference clock sync

    logic [1:0] phase;
    logic ref_prev;
    logic next_refclk_latched;
    logic slave_align;
    logic outclk_hold;
    logic next_refclk_out;

    // Output clock reset only counts once bit 0 has been cleared [R13]
    assign outclk_hold = !sync_reg[`ADS_DR_BIT] && output_clock_reset_in;

    // In slave mode a latched reference edge restarts the divider [R11]
    assign slave_align = sync_reg[`ADS_ES_BIT] && refclk_latched &&
                         !ref_prev;

    // Quarter-rate phase of the sampling clock
    ads_phase_div u_phase_div (
        .core_clk(core_clk),
        .resetn(resetn),
        .hold(outclk_hold),
        .load(slave_align),
        .phase(phase)
    );

    // Sample the reference only at the selected quarter phase [R10]
    always_comb begin
        next_refclk_latched = refclk_latched;
        if (phase == sync_reg[`ADS_SP_MSB:`ADS_SP_LSB]) begin
            next_refclk_latched = refclk_in;
        end
        // Outputs quiet while disabled, master or slave alike [R12]
        next_refclk_out = !sync_reg[`ADS_DOC_BIT] && phase[1];
    end

    // Sync registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            refclk_latched <= 1'b0;
            ref_prev <= 1'b0;
            refclk_out_a <= 1'b0;
            refclk_out_b <= 1'b0;
            refclk_out_oe <= 1'b0;
            sync_slave_mode <= 1'b0;
        end else begin
            refclk_latched <= next_refclk_latched;
            ref_prev <= refclk_latched;
            refclk_out_a <= next_refclk_out; // [R12]
            refclk_out_b <= next_refclk_out; // [R12]
            refclk_out_oe <= !sync_reg[`ADS_DOC_BIT]; // [R12]
            sync_slave_mode <= sync_reg[`ADS_ES_BIT]; // [R11]
        end
    end

    // Output data clock is the divider's top bit, a flop output
    assign outclk = phase[1];

endmodule : ads_aperture_sync

// ===== design/ads_regs.svh
// Purpose: Register map, field positions and constants of the aperture
//          delay and reference sync configuration block.
// Assumes: Four-bit register address carried in the serial frame header.
// Notes:   Definitions only.
`ifndef ADS_REGS_SVH
`define ADS_REGS_SVH

// Register addresses
`define ADS_ADDR_COARSE 4'hC
`define ADS_ADDR_FINE 4'hD
`define ADS_ADDR_SYNC 4'hE

// Power-on values
`define ADS_RST_COARSE 16'h0004
`define ADS_RST_FINE 16'h0000
`define ADS_RST_SYNC 16'h0003

// Coarse register fields
`define ADS_CAM_MSB 15
`define ADS_CAM_LSB 4
`define ADS_STA_BIT 3
`define ADS_DCC_BIT 2
`define ADS_COARSE_RSVD_MASK 16'hFFFC

// Fine register fields
`define ADS_FAM_MSB 15
`define ADS_FAM_LSB 10
`define ADS_FINE_RSVD_MASK 16'hFC00

// Sync register fields
`define ADS_DRC_MSB 15
`define ADS_DRC_LSB 7
`define ADS_SP_MSB 4
`define ADS_SP_LSB 3
`define ADS_ES_BIT 2
`define ADS_DOC_BIT 1
`define ADS_DR_BIT 0

// Saturation codes
`define ADS_CAM_SAT 12'h980
`define ADS_CAM_MAX 12'h97F
`define ADS_DRC_MAX 9'h13F
`define ADS_DRC_SAT 9'h27F

// Delay step sizes in femtoseconds
`define ADS_COARSE_STEP_FS 20'h00154
`define ADS_FINE_STEP_FS 20'h00024

// Serial frame layout
`define ADS_HDR_LAST 5'h07
`define ADS_FRAME_LAST 5'h17
`define ADS_HDR_RW_BIT 6
`define ADS_HDR_ADDR_MSB 2

`endif

// ===== design/ads_pkg.sv
// Purpose: Types shared by the aperture delay and sync configuration block.
// Assumes: Nothing beyond the register header.
// Notes:   Holds types only; numbers live in ads_regs.svh.
package ads_pkg;

    // Serial frame progress
    typedef enum logic [1:0] {
        ADS_SER_IDLE,
        ADS_SER_HDR,
        ADS_SER_DATA,
        ADS_SER_DONE
    } ads_ser_state_t;

endpackage : ads_pkg

// ===== design/ads_sat_clamp.sv
// Purpose: Saturating clamp of a delay code against its top usable code.
// Assumes: Purely combinational.
// Notes:   Used for both the coarse aperture and reference delay codes.
module ads_sat_clamp #(
    parameter int WIDTH = 12
) (
    // Code in
    input wire logic [WIDTH-1:0] code_in,
    input wire logic [WIDTH-1:0] code_max,
    // Code out
    output logic [WIDTH-1:0] code_out
);

    // Codes past the top hold at the top
    always_comb begin
        code_out = (code_in > code_max) ? code_max : code_in;
    end

endmodule : ads_sat_clamp

// ===== design/ads_phase_div.sv
// Purpose: Two-bit divider giving the quarter-rate phase of the clock.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Hold and load both force phase zero, so neither has priority.
module ads_phase_div (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Control
    input wire logic hold,
    input wire logic load,
    // Phase
    output logic [1:0] phase
);

    logic [1:0] next_phase;

    // Count, or restart at phase zero
    always_comb begin
        if (hold || load) begin
            next_phase = 2'h0;
        end else begin
            next_phase = phase + 2'h1;
        end
    end

    // Register the phase
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            phase <= 2'h0;
        end else begin
            phase <= next_phase;
        end
    end

endmodule : ads_phase_div

// ===== tb/ads_host_model.sv
// Purpose: Host controller model driving the serial configuration pins.
// Assumes: Pins change just after rising core_clk edges.
// Notes:   Serial clock rests low and sdi flips between frames.
module ads_host_model (
    // Clock
    input wire logic core_clk,
    // Serial pins
    output logic scs_n,
    output logic sclk,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle pins at time zero
    initial begin
        scs_n = 1'h1;
        sclk = 1'h0;
        sdi = 1'h0;
    end

    // One frame: R/W, spare bits, address, then 16 data bits, MSB first.
    // Fewer than 24 bits drops select mid-frame, which aborts it.
    task automatic xfer(input logic rd_en, input logic [3:0] addr,
            input logic [15:0] wdata, input int nbits,
            output logic [15:0] rdata);
        logic [23:0] frame;
        frame = {rd_en, 3'h0, addr, wdata};
        rdata = 16'h0000;
        @(posedge core_clk);
        scs_n <= 1'h0;
        for (int i = 0; i < nbits; i++) begin
            @(posedge core_clk);
            sdi <= frame[23-i];
            sclk <= 1'h1;
            repeat (2) @(posedge core_clk);
            sclk <= 1'h0;
            repeat (3) @(posedge core_clk);
            // Mid-cycle sample keeps clear of the update edge
            @(negedge core_clk);
            if (i >= 7 && i < 23)
                rdata = {rdata[14:0], sdo & sdo_oe};
        end
        @(posedge core_clk);
        scs_n <= 1'h1;
        sdi <= ~sdi; // Released line shows no stale bit
        repeat (3) @(posedge core_clk);
    endtask : xfer
endmodule : ads_host_model

// ===== tb/ads_aperture_sync_sva.sv
// Purpose: Port-level checks of the aperture delay and sync block.
// Assumes: One clock domain, active-low asynchronous reset.
// Notes:   The cadence check pauses while the divider may be realigned or held.
module ads_aperture_sync_sva (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Serial pins
    input wire logic scs_n,
    input wire logic sdo_oe,
    // Delay and sync signals
    input wire logic [19:0] aperture_delay_fs,
    input wire logic delay_adjust_active,
    input wire logic duty_stabiliser_enable,
    input wire logic output_clock_reset_in,
    input wire logic [8:0] refclk_delay,
    input wire logic refclk_latched,
    input wire logic sync_slave_mode,
    input wire logic refclk_out_a,
    input wire logic refclk_out_b,
    input wire logic refclk_out_oe,
    input wire logic outclk
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // Clamped coarse code 2431 plus fine code 63, in femtoseconds
    localparam logic [19:0] AP_MAX = 20'hCA588;

    sequence s_high2; outclk ##1 outclk; endsequence
    sequence s_low2; !outclk ##1 !outclk; endsequence

    property p_gate; !delay_adjust_active |-> aperture_delay_fs == 20'h0;
    endproperty
    a_gate: assert property (p_gate)
        else $error("delay applied while adjust is off");
    property p_max; aperture_delay_fs <= AP_MAX; endproperty
    a_max: assert property (p_max)
        else $error("aperture delay above the plateau");
    property p_drc; refclk_delay <= 9'h13F; endproperty
    a_drc: assert property (p_drc)
        else $error("reference delay above its plateau");
    property p_pair; refclk_out_a == refclk_out_b; endproperty
    a_pair: assert property (p_pair)
        else $error("reference outputs differ");
    property p_off; !refclk_out_oe |-> !refclk_out_a; endproperty
    a_off: assert property (p_off)
        else $error("reference output active while disabled");
    // Realignment or a held divider may legally break the cadence
    property p_qtr;
        disable iff (!resetn || sync_slave_mode || output_clock_reset_in)
        $rose(outclk) |-> s_high2 ##1 s_low2 ##1 outclk;
    endproperty
    a_qtr: assert property (p_qtr)
        else $error("divider output not quarter rate");
    property p_align;
        sync_slave_mode && !output_clock_reset_in && $rose(refclk_latched)
        |-> ##2 !outclk ##2 outclk;
    endproperty
    a_align: assert property (p_align)
        else $error("slave divider not realigned");
    property p_rst; $rose(resetn) |-> duty_stabiliser_enable &&
        !refclk_out_oe && !delay_adjust_active; endproperty
    a_rst: assert property (p_rst)
        else $error("wrong state after reset release");
    // A new frame must not inherit the data phase of an aborted one
    property p_sdo; $fell(scs_n) |-> !sdo_oe ##1 !sdo_oe; endproperty
    a_sdo: assert property (p_sdo)
        else $error("read data driven at frame start");
endmodule : ads_aperture_sync_sva

//////////////////////////////////////////////////////////////
bind ads_aperture_sync ads_aperture_sync_sva u_sva (
    .core_clk, .resetn, .scs_n, .sdo_oe, .aperture_delay_fs,
    .delay_adjust_active, .duty_stabiliser_enable, .output_clock_reset_in,
    .refclk_delay, .refclk_latched, .sync_slave_mode, .refclk_out_a,
    .refclk_out_b, .refclk_out_oe, .outclk
);

// ===== tb/ads_aperture_sync_test.sv
// Purpose: Register-level test of the aperture delay and sync block.
// Assumes: Host model frames every register access.
// Notes:   Steps are 340 fs coarse and 36 fs fine, as the design rounds.
`include "ads_regs.svh"
module ads_aperture_sync_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk;
    logic resetn;
    logic scs_n;
    logic sclk;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic [19:0] aperture_delay_fs;
    logic delay_adjust_active;
    logic duty_stabiliser_enable;
    logic refclk_in;
    logic output_clock_reset_in;
    logic [8:0] refclk_delay;
    logic refclk_latched;
    logic sync_slave_mode;
    logic refclk_out_a;
    logic refclk_out_b;
    logic refclk_out_oe;
    logic outclk;
    logic [15:0] rd;
    int failures;
    int checks_done;
    int ra;
    int ro;
    logic [11:0] cams [5] = '{12'h000, 12'h001, 12'h97F, 12'h980, 12'hFFF};
    logic [8:0] drcs [5] = '{9'h000, 9'h13F, 9'h140, 9'h27F, 9'h1FF};

    initial core_clk = 1'h0;
    always #5 core_clk = ~core_clk;

    ads_aperture_sync dut (
        .core_clk, .resetn, .scs_n, .sclk, .sdi, .sdo, .sdo_oe,
        .aperture_delay_fs, .delay_adjust_active, .duty_stabiliser_enable,
        .refclk_in, .output_clock_reset_in, .refclk_delay, .refclk_latched,
        .sync_slave_mode, .refclk_out_a, .refclk_out_b, .refclk_out_oe,
        .outclk
    );
    ads_host_model host (.core_clk, .scs_n, .sclk, .sdi, .sdo, .sdo_oe);

    //////////////////////////////////////////////////////////
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] unused;
        host.xfer(1'h0, a, d, 24, unused);
    endtask : wr

    task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
        host.xfer(1'h1, a, 16'h0000, 24, rd);
        chk({4'h0, rd}, {4'h0, exp});
    endtask : rdc

    // Rising edges of reference output and divider over n cycles
    task automatic count_rises(input int n);
        logic pa;
        logic po;
        pa = refclk_out_a;
        po = outclk;
        ra = 0;
        ro = 0;
        repeat (n) begin
            @(negedge core_clk);
            if (refclk_out_a && !pa) ra++;
            if (outclk && !po) ro++;
            pa = refclk_out_a;
            po = outclk;
        end
    endtask : count_rises

    function automatic logic [19:0] exp_ap(input logic [11:0] c,
            input logic [5:0] f);
        logic [11:0] cc;
        cc = (c > `ADS_CAM_MAX) ? `ADS_CAM_MAX : c;
        return 20'(cc) * `ADS_COARSE_STEP_FS + 20'(f) * `ADS_FINE_STEP_FS;
    endfunction : exp_ap

    // About thirty frames of under 200 cycles each; 30k cycles is ample
    initial begin
        #300000;
        failures++;
        report_and_stop();
    end

    //////////////////////////////////////////////////////////
    initial begin
        resetn = 1'h0;
        refclk_in = 1'h0;
        output_clock_reset_in = 1'h0;
        failures = 0;
        checks_done = 0;
        repeat (10) @(posedge core_clk);
        resetn <= 1'h1;
        repeat (2) @(posedge core_clk);
        chk(duty_stabiliser_enable, 1'h1);
        chk(refclk_out_oe, 1'h0);
        rdc(`ADS_ADDR_COARSE, 16'h0004);
        rdc(`ADS_ADDR_FINE, 16'h0000);
        rdc(`ADS_ADDR_SYNC, 16'h0003);
        rdc(4'hF, 16'h0000);
        // Settings stay inert while the adjust bit is clear
        wr(`ADS_ADDR_FINE, 16'hA800);
        wr(`ADS_ADDR_COARSE, {12'h064, 4'h4});
        chk(aperture_delay_fs, 20'h00000);
        // Coarse codes either side of saturation, top fine code
        wr(`ADS_ADDR_FINE, 16'hFC00);
        // Bench models no interleaved mode, so adjust may be enabled
        foreach (cams[i]) begin
            wr(`ADS_ADDR_COARSE, {cams[i], 4'h8});
            chk(aperture_delay_fs, exp_ap(cams[i], 6'h3F));
        end
        chk(duty_stabiliser_enable, 1'h0);
        chk(delay_adjust_active, 1'h1);
        rdc(`ADS_ADDR_COARSE, 16'hFFF8);
        // Leave the coarse code well below its maximum from here on
        wr(`ADS_ADDR_COARSE, 16'h0008);
        wr(`ADS_ADDR_FINE, 16'hA800);
        chk(aperture_delay_fs, exp_ap(12'h000, 6'h2A));
        // A frame cut short must leave the register untouched
        host.xfer(1'h0, `ADS_ADDR_FINE, 16'h0400, 12, rd);
        rdc(`ADS_ADDR_FINE, 16'hA800);
        foreach (drcs[i]) begin
            wr(`ADS_ADDR_SYNC, {drcs[i], 7'h03});
            chk(refclk_delay,
                (drcs[i] > `ADS_DRC_MAX) ? `ADS_DRC_MAX : drcs[i]);
        end
        // Outputs on, reset input ignored while its function is off
        wr(`ADS_ADDR_SYNC, 16'h0001);
        output_clock_reset_in <= 1'h1;
        count_rises(32);
        chk(refclk_out_oe, 1'h1);
        chk(20'(ra), 20'h00008);
        wr(`ADS_ADDR_SYNC, 16'h0000);
        repeat (2) @(posedge core_clk);
        count_rises(16);
        chk(20'(ro), 20'h00000);
        output_clock_reset_in <= 1'h0;
        // Each latch phase in slave mode
        for (int sp = 0; sp < 4; sp++) begin
            wr(`ADS_ADDR_SYNC, {9'h000, 2'h0, 2'(sp), 3'h7});
            chk(sync_slave_mode, 1'h1);
            refclk_in <= 1'h1;
            repeat (8) @(posedge core_clk);
            chk(refclk_latched, 1'h1);
            refclk_in <= 1'h0;
            repeat (8) @(posedge core_clk);
            chk(refclk_latched, 1'h0);
        end
        wr(`ADS_ADDR_SYNC, 16'h0003);
        chk(sync_slave_mode, 1'h0);
        report_and_stop();
    end
endmodule : ads_aperture_sync_test
